// ---- dv/ppoc_switch.sv ----
`timescale 1ns/1ps
module ppoc_switch (
    // clock
    input wire logic clk_i,
    // lanes 0..5 port pins, lane 6 shared pin
    input wire logic [6:0] oe_n_i,
    input wire logic [6:0] pullup_i,
    input wire logic [6:0] fault_i,
    output logic [6:0] level_o
);
    logic flip_reg = 1'b0;
    always_ff @(posedge clk_i) flip_reg <= ~flip_reg;
    // open-drain fault pulls low; a floating pin wanders, never holds
    assign level_o = oe_n_i & ~fault_i & (pullup_i | {7{flip_reg}});
endmodule : ppoc_switch

// ---- dv/ppoc_top_props.sv ----
`timescale 1ns/1ps
module ppoc_top_props #(
    parameter int NUM_PORTS = ppoc_pkg::NUM_PORTS,
    parameter int TICK_CYCLES = ppoc_pkg::TICK_CYCLES
) (
    // clock, reset and configuration
    input wire logic CLK_SYS_I,
    input wire logic RESET_N_I,
    input wire logic GANGED_MODE_I,
    input wire logic [3:0] SINGLE_WIDTH_I,
    input wire logic [7:0] DOUBLE_WINDOW_I,
    input wire logic [7:0] LOCKOUT_I,
    input wire logic [NUM_PORTS-1:0] CHARGE_CAP_I,
    // power requests and flags
    input wire logic [NUM_PORTS-1:0] PORT_POWER_I,
    input wire logic [NUM_PORTS-1:0] PORT_OC_O,
    input wire logic GANGED_ACTIVE_O,
    // pins
    input wire logic [NUM_PORTS-1:0] PORT_CTL_PINS_I,
    input wire logic [NUM_PORTS-1:0] PORT_CTL_PINS_O,
    input wire logic [NUM_PORTS-1:0] PORT_CTL_PINS_OE_N_O,
    input wire logic [NUM_PORTS-1:0] PORT_CTL_PULLUP_O,
    input wire logic SHARED_POWER_SENSE_PIN_I,
    input wire logic SHARED_POWER_SENSE_PIN_O,
    input wire logic SHARED_POWER_SENSE_PIN_OE_N_O,
    input wire logic SHARED_POWER_SENSE_PULLUP_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESET_N_I);
    sequence s_individual; (!GANGED_ACTIVE_O) [*3]; endsequence
    sequence s_all_off; (!GANGED_ACTIVE_O && PORT_POWER_I == '0) [*4];
    endsequence
    a_off_low_drive: assert property (1'b1 |=> GANGED_ACTIVE_O ||
        ((PORT_CTL_PINS_OE_N_O | PORT_CTL_PULLUP_O) &
        ~($past(PORT_POWER_I) | $past(CHARGE_CAP_I))) == '0)
        else $error("off port pin not driven low");
    a_on_released: assert property (1'b1 |=> GANGED_ACTIVE_O ||
        ((~PORT_CTL_PINS_OE_N_O | ~PORT_CTL_PULLUP_O) &
        $past(PORT_POWER_I)) == '0) else $error("on port pin not released");
    a_shared_idle: assert property (s_individual |->
        SHARED_POWER_SENSE_PIN_OE_N_O && !SHARED_POWER_SENSE_PULLUP_O)
        else $error("shared pin active in individual mode");
    a_ganged_power: assert property (
        GANGED_ACTIVE_O && |PORT_POWER_I |=>
        SHARED_POWER_SENSE_PIN_OE_N_O && SHARED_POWER_SENSE_PULLUP_O &&
        PORT_CTL_PINS_OE_N_O == '1 && PORT_CTL_PULLUP_O == '0)
        else $error("ganged pin roles wrong");
    a_ganged_all: assert property (GANGED_ACTIVE_O |->
        PORT_OC_O == '0 || PORT_OC_O == '1) else $error("ganged flags differ");
    a_oc_clears: assert property (s_all_off |-> PORT_OC_O == '0)
        else $error("flag kept after power off");
    a_lockout_quiet: assert property (
        $rose(|PORT_POWER_I) && !GANGED_ACTIVE_O |=> (PORT_OC_O == '0) [*8])
        else $error("flag during lockout");
    a_low_cause: assert property (
        !GANGED_ACTIVE_O && $rose(|PORT_OC_O) |-> |(PORT_OC_O &
        ~($past(PORT_CTL_PINS_I, 3) & $past(PORT_CTL_PINS_I, 4))))
        else $error("flag without low pin");
endmodule : ppoc_top_props
bind ppoc_top ppoc_top_props #(.NUM_PORTS(NUM_PORTS),
    .TICK_CYCLES(TICK_CYCLES)) u_ppoc_top_props (.*);

// ---- dv/test_ppoc_top.sv ----
`timescale 1ns/1ps
module test_ppoc_top;
    localparam int TK = 20;
    logic CLK_SYS_I = 1'b0;
    logic RESET_N_I = 1'b0;
    logic GANGED_MODE_I = 1'b0;
    logic [3:0] SINGLE_WIDTH_I = 4'h0;
    logic [7:0] DOUBLE_WINDOW_I = 8'h03, LOCKOUT_I = 8'h02;
    logic [5:0] CHARGE_CAP_I = 6'h00, PORT_POWER_I = 6'h00;
    logic [5:0] PORT_OC_O, PORT_CTL_PINS_I, PORT_CTL_PINS_O;
    logic [5:0] PORT_CTL_PINS_OE_N_O, PORT_CTL_PULLUP_O;
    logic GANGED_ACTIVE_O, SHARED_POWER_SENSE_PIN_I;
    logic SHARED_POWER_SENSE_PIN_O, SHARED_POWER_SENSE_PIN_OE_N_O;
    logic SHARED_POWER_SENSE_PULLUP_O;
    logic [6:0] fault = 7'h00;
    integer errors = 0, total_checks = 0, cycles = 0, p, w;
    integer seed = 32'had54;
    always #20 CLK_SYS_I = ~CLK_SYS_I;
    ppoc_top #(.TICK_CYCLES(TK)) u_ppoc_top (.*);
    ppoc_switch u_ppoc_switch (
        .clk_i(CLK_SYS_I),
        .oe_n_i({SHARED_POWER_SENSE_PIN_OE_N_O, PORT_CTL_PINS_OE_N_O}),
        .pullup_i({SHARED_POWER_SENSE_PULLUP_O, PORT_CTL_PULLUP_O}),
        .fault_i(fault),
        .level_o({SHARED_POWER_SENSE_PIN_I, PORT_CTL_PINS_I})
    );
    // released pins: powered or charging ports, or all in ganged mode
    function automatic logic [11:0] exp_pins();
        return GANGED_MODE_I ? 12'hfc0 : {2{PORT_POWER_I | CHARGE_CAP_I}};
    endfunction : exp_pins
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_pins();
        chk({PORT_CTL_PINS_OE_N_O, PORT_CTL_PULLUP_O}, exp_pins());
    endtask : chk_pins
    task automatic cyc(input int n);
        repeat (n) @(negedge CLK_SYS_I);
    endtask : cyc
    task automatic low(input int q, input int n);
        fault[q] = 1'b1;
        cyc(n);
        fault[q] = 1'b0;
    endtask : low
    task automatic do_reset(input logic g);
        RESET_N_I = 1'b0;
        GANGED_MODE_I = g;
        PORT_POWER_I = 6'h00;
        cyc(10);
        RESET_N_I = 1'b1;
        cyc(3);
    endtask : do_reset
    task automatic finish_test();
        $display("checks %0d, errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test
    always @(posedge CLK_SYS_I) begin
        cycles++;
        if (cycles == 8000) begin
            errors++;
            finish_test();
        end
    end
    initial begin
        do_reset(1'b0);
        chk(GANGED_ACTIVE_O, 1'b0);
        chk({SHARED_POWER_SENSE_PIN_OE_N_O, SHARED_POWER_SENSE_PULLUP_O},
            2'b10);
        chk_pins();
        chk({PORT_CTL_PINS_O, SHARED_POWER_SENSE_PIN_O}, 7'h00);
        DOUBLE_WINDOW_I = 8'(2 + {$random(seed)} % 4);
        // every width code from 0 to 5; a short group first must not trigger
        for (w = 0; w < 6; w++) begin
            p = {$random(seed)} % 6;
            CHARGE_CAP_I = 6'($random(seed));
            SINGLE_WIDTH_I = w[3:0];
            PORT_POWER_I[p] = 1'b1;
            cyc(2);
            chk_pins();
            low(p, TK - 10);
            cyc(2 * TK);
            chk(PORT_OC_O, 6'h00);
            if (w > 1) begin
                low(p, (w - 1) * TK - 5);
                cyc(DOUBLE_WINDOW_I * TK + TK);
                chk(PORT_OC_O, 6'h00);
            end
            low(p, w * TK + 10);
            cyc(5);
            chk(PORT_OC_O, 6'h01 << p);
            PORT_POWER_I[p] = 1'b0;
            cyc(3);
            chk(PORT_OC_O, 6'h00);
            chk_pins();
        end
        // two short groups: inside the window, then beyond it
        SINGLE_WIDTH_I = 4'h5;
        for (w = 0; w < 2; w++) begin
            p = {$random(seed)} % 6;
            PORT_POWER_I[p] = 1'b1;
            cyc(3 * TK);
            low(p, 5);
            cyc(w ? (DOUBLE_WINDOW_I + 2) * TK : 10);
            low(p, 5);
            cyc(6);
            chk(PORT_OC_O, w ? 6'h00 : 6'h01 << p);
            PORT_POWER_I[p] = 1'b0;
            cyc(4);
        end
        // codes above five select no width: one long low is ignored
        SINGLE_WIDTH_I = 4'(6 + {$random(seed)} % 10);
        p = {$random(seed)} % 6;
        PORT_POWER_I[p] = 1'b1;
        cyc(3 * TK);
        low(p, 7 * TK);
        chk(PORT_OC_O, 6'h00);
        PORT_POWER_I[p] = 1'b0;
        cyc(4);
        do_reset(1'b1);
        chk(GANGED_ACTIVE_O, 1'b1);
        PORT_POWER_I = 6'h01 << ({$random(seed)} % 6);
        cyc(2);
        chk_pins();
        chk({SHARED_POWER_SENSE_PIN_OE_N_O, SHARED_POWER_SENSE_PULLUP_O},
            2'b11);
        cyc(3 * TK);
        SINGLE_WIDTH_I = 4'h1;
        low(6, 2 * TK);
        chk(PORT_OC_O, 6'h3f);
        chk({PORT_CTL_PINS_O, SHARED_POWER_SENSE_PIN_O}, 7'h00);
        PORT_POWER_I = 6'h00;
        cyc(3);
        chk({SHARED_POWER_SENSE_PIN_OE_N_O, SHARED_POWER_SENSE_PULLUP_O,
            SHARED_POWER_SENSE_PIN_O}, 3'b000);
        chk(PORT_OC_O, 6'h00);
        finish_test();
    end
endmodule : test_ppoc_top

// ---- verilog/ppoc_pkg.sv ----
package ppoc_pkg;
    // timebase: 1 ms at the 25 MHz core clock
    localparam int CLK_HZ = 25000000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int NUM_PORTS = 6;
    localparam logic [3:0] SINGLE_WIDTH_RST = 4'h0;
    localparam logic [3:0] SINGLE_WIDTH_MAX = 4'h5;
    localparam logic [7:0] DOUBLE_WINDOW_RST = 8'h14;
    localparam logic [7:0] LOCKOUT_RST = 8'h0a;
    localparam logic GANGED_RST = 1'b0;
endpackage : ppoc_pkg

// ---- verilog/ppoc_port.sv ----
`timescale 1ns/1ps
module ppoc_port #(
    parameter int TICK_CYCLES = ppoc_pkg::TICK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic tick_i,
    input wire logic power_i,
    input wire logic sense_i,
    input wire logic [3:0] single_width_i,
    input wire logic [7:0] double_window_i,
    input wire logic [7:0] lockout_i,
    output logic oc_o
);
    typedef enum logic [2:0] {
        PPOC_OFF = 3'b001,
        PPOC_LOCK = 3'b010,
        PPOC_WATCH = 3'b100
    } ppoc_state_e;

    ppoc_state_e state_reg, state_next;
    logic [7:0] lock_cnt_reg, lock_cnt_next;
    logic [15:0] low_cyc_reg, low_cyc_next;
    logic [3:0] low_ms_reg, low_ms_next;
    logic [7:0] win_cnt_reg, win_cnt_next;
    logic win_open_reg, win_open_next;
    logic prev_low_reg, prev_low_next;
    logic oc_reg, oc_next;
    logic low;
    logic group_start;

    assign low = ~sense_i;
    assign group_start = low & ~prev_low_reg;

    always_comb begin
        state_next = state_reg;
        lock_cnt_next = lock_cnt_reg;
        low_cyc_next = low_cyc_reg;
        low_ms_next = low_ms_reg;
        win_cnt_next = win_cnt_reg;
        win_open_next = win_open_reg;
        prev_low_next = prev_low_reg;
        oc_next = oc_reg;
        case (state_reg)
            PPOC_OFF: begin
                oc_next = 1'b0;
                if (power_i) begin
                    state_next = PPOC_LOCK;
                    lock_cnt_next = lockout_i;
                end
            end
            PPOC_LOCK: begin
                // pin ignored while the supply ramps
                if (!power_i) begin
                    state_next = PPOC_OFF;
                end else if (lock_cnt_reg == 8'h00) begin
                    state_next = PPOC_WATCH;
                    low_cyc_next = 16'h0000;
                    low_ms_next = 4'h0;
                    win_open_next = 1'b0;
                    prev_low_next = 1'b0;
                end else if (tick_i) begin
                    lock_cnt_next = lock_cnt_reg - 8'h01;
                end
            end
            PPOC_WATCH: begin
                prev_low_next = low;
                if (!power_i) begin
                    state_next = PPOC_OFF;
                end else begin
                    // single pulse width counted in whole ms
                    if (!low) begin
                        low_cyc_next = 16'h0000;
                        low_ms_next = 4'h0;
                    end else if (low_ms_reg < single_width_i) begin
                        // same ms length as the shared tick
                        if (low_cyc_reg == 16'(TICK_CYCLES - 1)) begin
                            low_cyc_next = 16'h0000;
                            low_ms_next = low_ms_reg + 4'h1;
                        end else begin
                            low_cyc_next = low_cyc_reg + 16'h0001;
                        end
                    end
                    if (low && (low_ms_reg >= single_width_i) &&
                        (single_width_i <= ppoc_pkg::SINGLE_WIDTH_MAX)) begin
                        oc_next = 1'b1;
                    end
                    // rolling double pulse window
                    if (win_open_reg && tick_i) begin
                        if (win_cnt_reg <= 8'h01) begin
                            win_open_next = 1'b0;
                        end else begin
                            win_cnt_next = win_cnt_reg - 8'h01;
                        end
                    end
                    if (group_start) begin
                        if (win_open_reg) begin
                            oc_next = 1'b1;
                        end else begin
                            win_open_next = 1'b1;
                            win_cnt_next = double_window_i;
                        end
                    end
                end
            end
            default: begin
                state_next = PPOC_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= PPOC_OFF;
            lock_cnt_reg <= 8'h00;
            low_cyc_reg <= 16'h0000;
            low_ms_reg <= 4'h0;
            win_cnt_reg <= 8'h00;
            win_open_reg <= 1'b0;
            prev_low_reg <= 1'b0;
            oc_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            lock_cnt_reg <= lock_cnt_next;
            low_cyc_reg <= low_cyc_next;
            low_ms_reg <= low_ms_next;
            win_cnt_reg <= win_cnt_next;
            win_open_reg <= win_open_next;
            prev_low_reg <= prev_low_next;
            oc_reg <= oc_next;
        end
    end

    assign oc_o = oc_reg;
endmodule : ppoc_port

// ---- verilog/ppoc_top.sv ----
// Operation
// - each port pin can signal presence of a charging capable supply
// - exactly one mode: ganged shared pin or one pin per port
// - ganged mode set by configuration; shared pin serves all ports
// - ganged overcurrent flags every port at once
// - reset selects individual mode, one pin per port; the first clock after release loads GANGED_MODE_I
// - power off: drive pin low, pull-up off; in individual mode charge capable ports stay released with pull-up on
// - power on: release driver, pull-up on, open-drain high
// - enabled port pin sampled continuously
// - low lasting the single-pulse width declares overcurrent
// - two low groups within the rolling window declare overcurrent
// - filtering rejects transient lows such as power-up sag
// - single width is 4-bit code, 0 to 5 ms in 1 ms steps
// - double window 8-bit ms count, reset 20, never zero
// - overcurrent ignored for lockout ms after power on, reset 10
`timescale 1ns/1ps
module ppoc_top #(
    parameter int NUM_PORTS = ppoc_pkg::NUM_PORTS,
    parameter int TICK_CYCLES = ppoc_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic CLK_SYS_I,
    input wire logic RESET_N_I,
    // configuration
    input wire logic GANGED_MODE_I,
    input wire logic [3:0] SINGLE_WIDTH_I,
    input wire logic [7:0] DOUBLE_WINDOW_I,
    input wire logic [7:0] LOCKOUT_I,
    input wire logic [NUM_PORTS-1:0] CHARGE_CAP_I,
    // port power requests and overcurrent flags
    input wire logic [NUM_PORTS-1:0] PORT_POWER_I,
    output logic [NUM_PORTS-1:0] PORT_OC_O,
    output logic GANGED_ACTIVE_O,
    // individual port pins
    input wire logic [NUM_PORTS-1:0] PORT_CTL_PINS_I,
    output logic [NUM_PORTS-1:0] PORT_CTL_PINS_O,
    output logic [NUM_PORTS-1:0] PORT_CTL_PINS_OE_N_O,
    output logic [NUM_PORTS-1:0] PORT_CTL_PULLUP_O,
    // shared pin
    input wire logic SHARED_POWER_SENSE_PIN_I,
    output logic SHARED_POWER_SENSE_PIN_O,
    output logic SHARED_POWER_SENSE_PIN_OE_N_O,
    output logic SHARED_POWER_SENSE_PULLUP_O
);
    logic [NUM_PORTS-1:0] pin_s1_reg, pin_s1_next;
    logic [NUM_PORTS-1:0] pin_s2_reg, pin_s2_next;
    logic gang_s1_reg, gang_s1_next;
    logic gang_s2_reg, gang_s2_next;
    logic ganged_reg, ganged_next;
    logic cfg_done_reg, cfg_done_next;
    logic [15:0] tick_cnt_reg, tick_cnt_next;
    logic tick_reg, tick_next;
    logic [NUM_PORTS-1:0] out_reg, out_next;
    logic [NUM_PORTS-1:0] oe_n_reg, oe_n_next;
    logic [NUM_PORTS-1:0] pu_reg, pu_next;
    logic gout_reg, gout_next;
    logic goe_n_reg, goe_n_next;
    logic gpu_reg, gpu_next;
    logic [NUM_PORTS-1:0] ind_oc;
    logic gang_oc;
    logic gang_power;

    assign gang_power = |PORT_POWER_I;

    // mode is caught once after reset release, so no mid-run mode flips
    always_comb begin
        ganged_next = ganged_reg;
        cfg_done_next = 1'b1;
        if (!cfg_done_reg) begin
            ganged_next = GANGED_MODE_I;
        end
    end

    always_comb begin
        pin_s1_next = PORT_CTL_PINS_I;
        pin_s2_next = pin_s1_reg;
        gang_s1_next = SHARED_POWER_SENSE_PIN_I;
        gang_s2_next = gang_s1_reg;
        tick_next = 1'b0;
        tick_cnt_next = tick_cnt_reg + 16'h0001;
        if (tick_cnt_reg == 16'(TICK_CYCLES - 1)) begin
            tick_cnt_next = 16'h0000;
            tick_next = 1'b1;
        end
    end

    // pin drive: individual pins low with pull-up off when unpowered and not charge capable, else open-drain high; ganged: shared pin low while all off
    always_comb begin
        out_next = '0;
        oe_n_next = '1;
        pu_next = '0;
        gout_next = 1'b0;
        goe_n_next = 1'b1;
        gpu_next = 1'b0;
        if (ganged_reg) begin
            goe_n_next = gang_power;
            gpu_next = gang_power;
        end else begin
            for (int i = 0; i < NUM_PORTS; i++) begin
                // charge capable ports keep released high when off
                if (PORT_POWER_I[i] || CHARGE_CAP_I[i]) begin
                    oe_n_next[i] = 1'b1;
                    pu_next[i] = 1'b1;
                end else begin
                    oe_n_next[i] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ganged_reg <= ppoc_pkg::GANGED_RST;
            cfg_done_reg <= 1'b0;
            pin_s1_reg <= '1;
            pin_s2_reg <= '1;
            gang_s1_reg <= 1'b1;
            gang_s2_reg <= 1'b1;
            tick_cnt_reg <= 16'h0000;
            tick_reg <= 1'b0;
            out_reg <= '0;
            oe_n_reg <= '0;
            pu_reg <= '0;
            gout_reg <= 1'b0;
            goe_n_reg <= 1'b0;
            gpu_reg <= 1'b0;
        end else begin
            ganged_reg <= ganged_next;
            cfg_done_reg <= cfg_done_next;
            pin_s1_reg <= pin_s1_next;
            pin_s2_reg <= pin_s2_next;
            gang_s1_reg <= gang_s1_next;
            gang_s2_reg <= gang_s2_next;
            tick_cnt_reg <= tick_cnt_next;
            tick_reg <= tick_next;
            out_reg <= out_next;
            oe_n_reg <= oe_n_next;
            pu_reg <= pu_next;
            gout_reg <= gout_next;
            goe_n_reg <= goe_n_next;
            gpu_reg <= gpu_next;
        end
    end

    // one filter per pin; the external switch pulls low on fault
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        ppoc_port #(.TICK_CYCLES(TICK_CYCLES)) u_port (
            .clk_i(CLK_SYS_I),
            .rst_n_i(RESET_N_I),
            .tick_i(tick_reg),
            .power_i(PORT_POWER_I[p] & ~ganged_reg),
            .sense_i(pin_s2_reg[p]),
            .single_width_i(SINGLE_WIDTH_I),
            .double_window_i(DOUBLE_WINDOW_I),
            .lockout_i(LOCKOUT_I),
            .oc_o(ind_oc[p])
        );
    end

    ppoc_port #(.TICK_CYCLES(TICK_CYCLES)) u_gang (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RESET_N_I),
        .tick_i(tick_reg),
        .power_i(gang_power & ganged_reg),
        .sense_i(gang_s2_reg),
        .single_width_i(SINGLE_WIDTH_I),
        .double_window_i(DOUBLE_WINDOW_I),
        .lockout_i(LOCKOUT_I),
        .oc_o(gang_oc)
    );

    // one shared fault marks every port
    assign PORT_OC_O = ganged_reg ? {NUM_PORTS{gang_oc}} : ind_oc;
    assign GANGED_ACTIVE_O = ganged_reg;
    assign PORT_CTL_PINS_O = out_reg;
    assign PORT_CTL_PINS_OE_N_O = oe_n_reg;
    assign PORT_CTL_PULLUP_O = pu_reg;
    assign SHARED_POWER_SENSE_PIN_O = gout_reg;
    assign SHARED_POWER_SENSE_PIN_OE_N_O = goe_n_reg;
    assign SHARED_POWER_SENSE_PULLUP_O = gpu_reg;
endmodule : ppoc_top
